// *** hdl/irf_lvl_sync.sv ***
`timescale 1ns/10ps
// ---------------------------------------------------------------
// Request level synchroniser and debouncer.
// ---------------------------------------------------------------
module irf_lvl_sync (
	input wire logic i_sys_clk,
	input wire logic i_rst_b,
	irf_lvl_if.filt lvl
);
	logic [2:0] meta_q, meta_d; // First stage, read by the second only.
	logic [2:0] sync_q, sync_d; // Second stage.
	logic [2:0] prev_q, prev_d; // Previous settled sample.
	logic [2:0] lvl_q, lvl_d; // Accepted level.

	// A level is accepted only when it held over two clock periods.
	always_comb
	begin
		meta_d = lvl.raw;
		sync_d = meta_q;
		prev_d = sync_q;
		lvl_d = (sync_q == prev_q) ? sync_q : lvl_q;
	end

	// Registers only; the reset value means no request.
	always_ff @(posedge i_sys_clk or negedge i_rst_b)
	begin
		if (!i_rst_b)
		begin
			meta_q <= 3'h0;
			sync_q <= 3'h0;
			prev_q <= 3'h0;
			lvl_q <= 3'h0;
		end
		else
		begin
			meta_q <= meta_d;
			sync_q <= sync_d;
			prev_q <= prev_d;
			lvl_q <= lvl_d;
		end
	end

	assign lvl.level = lvl_q;

	// A change on the settled stage must wait a second period.
	property p_debounce;
		@(posedge i_sys_clk) disable iff (!i_rst_b)
		(sync_q != prev_q) |=> (lvl_q == $past(lvl_q));
	endproperty
	a_debounce: assert property (p_debounce) else $error("level taken too early");
endmodule : irf_lvl_sync

// *** hdl/irf_top.sv ***
// Added by the designer: register access over APB and the address map.
`timescale 1ns/10ps
// ---------------------------------------------------------------
// Interrupt recognition, exception return checks, fault status word.
// ---------------------------------------------------------------
module irf_top (
	input wire logic i_sys_clk,
	input wire logic i_rst_b,
	input wire logic i_psel,
	input wire logic i_penable,
	input wire logic i_pwrite,
	input wire logic [7:0] i_paddr,
	input wire logic [31:0] i_pwdata,
	output logic [31:0] o_prdata,
	output logic o_pready,
	output logic o_pslverr,
	input wire logic [2:0] i_irq_level,
	input wire logic i_insn_boundary,
	input wire logic [31:0] i_next_pc,
	output logic o_iack_req,
	output logic [3:0] o_iack_space,
	output logic [2:0] o_iack_level,
	input wire logic i_iack_done,
	input wire logic i_iack_autovec,
	input wire logic i_iack_berr,
	input wire logic [7:0] i_iack_vector,
	output logic o_push_req,
	output logic [7:0] o_push_vector,
	output logic [31:0] o_push_pc,
	output logic [15:0] o_push_sr,
	input wire logic i_push_done,
	input wire logic i_frame_fault,
	output logic o_fmt_err,
	output logic o_bus_err,
	output logic o_rewrite_req,
	input wire logic i_rewrite_done,
	input wire logic i_rewrite_berr,
	output logic o_rerun_req,
	output logic o_rerun_read,
	output logic [1:0] o_rerun_size,
	output logic [2:0] o_rerun_space,
	input wire logic i_rerun_done,
	output logic o_halt,
	input wire logic i_flt_capture,
	input wire logic i_flt_in_exc,
	input wire logic i_flt_block_move,
	input wire logic i_flt_refetch,
	input wire logic i_flt_trace_pend,
	input wire logic i_flt_ext_brk,
	input wire logic i_flt_int_brk,
	input wire logic i_flt_released,
	input wire logic i_flt_locked,
	input wire logic i_flt_prefetch,
	input wire logic i_flt_read,
	input wire logic i_flt_long,
	input wire logic [1:0] i_flt_size,
	input wire logic [2:0] i_flt_space
);
	// ---------------------------------------------------------------
	// Request level filter
	// ---------------------------------------------------------------
	irf_lvl_if lvl_bus ();
	assign lvl_bus.raw = i_irq_level;
	irf_lvl_sync u_sync (
		.i_sys_clk(i_sys_clk),
		.i_rst_b(i_rst_b),
		.lvl(lvl_bus)
	);
	logic [2:0] lvl; // Debounced request level.
	assign lvl = lvl_bus.level;

	// ---------------------------------------------------------------
	// Register state
	// ---------------------------------------------------------------
	typedef enum logic [1:0] {IRQ_IDLE, IRQ_ACK, IRQ_PUSH} irf_irq_st_t;
	typedef enum logic [2:0] {RT_IDLE, RT_CHECK, RT_REWRITE, RT_RERUN, RT_HALT} irf_rt_st_t;
	logic [15:0] sr_q, sr_d; // Live status register.
	logic [15:0] saved_q, saved_d; // Copy made when an interrupt is taken.
	logic [2:0] lvl_prev_q, lvl_prev_d; // Level one cycle ago.
	logic [2:0] mask_prev_q, mask_prev_d; // Mask one cycle ago.
	logic nmi_q, nmi_d; // Pending nonmaskable request.
	irf_irq_st_t ist_q, ist_d; // Interrupt sequencer.
	logic [2:0] acc_q, acc_d; // Accepted level.
	logic [7:0] vec_q, vec_d; // Vector number to push.
	logic [31:0] pc_q, pc_d; // Pre-empted program counter.
	irf_rt_st_t rst_q, rst_d; // Return sequencer.
	logic [19:0] frame_q, frame_d; // Format and internal word of the frame.
	logic [15:0] rssw_q, rssw_d; // Stacked status word handed back.
	logic [15:0] rsr_q, rsr_d; // Stacked status register handed back.
	irf_pkg::irf_rte_res_t res_q, res_d; // Last return outcome.
	logic [4:0] rel_q, rel_d; // Bytes of stack released.
	logic fmt_err_q, fmt_err_d; // One-cycle format error pulse.
	logic bus_err_q, bus_err_d; // One-cycle bus error pulse.
	logic [15:0] fssw_q, fssw_d; // Fault status word for stacking.
	logic [31:0] rdata_q, rdata_d; // Read data held for the access phase.
	logic wr_en; // Write in its access phase.
	logic rd_setup; // Read in its setup cycle.
	logic mapped; // Address hits a register.
	logic take; // Interrupt accepted this cycle.
	logic nmi_edge; // Level seven edge seen this cycle.

	// ---------------------------------------------------------------
	// APB slave
	// ---------------------------------------------------------------
	// Every access completes in its first access cycle; read data is
	// captured in setup so the bus sees a flop, not a mux.
	always_comb
	begin
		unique case (i_paddr)
			irf_pkg::OFS_SR, irf_pkg::OFS_SAVED_SR, irf_pkg::OFS_CMD,
			irf_pkg::OFS_IRQ_STAT, irf_pkg::OFS_RTE_FRAME, irf_pkg::OFS_RTE_SSW,
			irf_pkg::OFS_RTE_SR, irf_pkg::OFS_RTE_STAT, irf_pkg::OFS_FAULT_SSW: mapped = 1'b1;
			default: mapped = 1'b0;
		endcase
		wr_en = i_psel & i_penable & i_pwrite & mapped;
		rd_setup = i_psel & ~i_penable & ~i_pwrite;
		rdata_d = rdata_q;
		if (rd_setup)
		begin
			unique case (i_paddr)
				irf_pkg::OFS_SR: rdata_d = {16'h0000, sr_q};
				irf_pkg::OFS_SAVED_SR: rdata_d = {16'h0000, saved_q};
				irf_pkg::OFS_IRQ_STAT: rdata_d = {16'h0000, vec_q, 3'h0,
					(ist_q != IRQ_IDLE), nmi_q, lvl};
				irf_pkg::OFS_RTE_FRAME: rdata_d = {12'h000, frame_q};
				irf_pkg::OFS_RTE_SSW: rdata_d = {16'h0000, rssw_q};
				irf_pkg::OFS_RTE_SR: rdata_d = {16'h0000, rsr_q};
				irf_pkg::OFS_RTE_STAT: rdata_d = {19'h00000, rel_q, 5'h00,
					(rst_q == RT_HALT), res_q};
				irf_pkg::OFS_FAULT_SSW: rdata_d = {16'h0000, fssw_q};
				default: rdata_d = 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge i_sys_clk or negedge i_rst_b)
	begin
		if (!i_rst_b)
			rdata_q <= 32'h0000_0000;
		else
			rdata_q <= rdata_d;
	end

	assign o_prdata = rdata_q;
	assign o_pready = i_psel & i_penable;
	assign o_pslverr = i_psel & i_penable & ~mapped;

	// ---------------------------------------------------------------
	// Interrupt recognition and acknowledge
	// ---------------------------------------------------------------
	// Requests are never latched except the level seven edge; a
	// source that drops early is simply lost.
	always_comb
	begin
		lvl_prev_d = lvl;
		mask_prev_d = sr_q[2:0];
		// New seven, or mask leaving seven while seven is held.
		nmi_edge = ((lvl == irf_pkg::LVL_NMI) && (lvl_prev_q != irf_pkg::LVL_NMI))
			|| ((lvl == irf_pkg::LVL_NMI) && (mask_prev_q == irf_pkg::LVL_NMI)
			&& (sr_q[2:0] != irf_pkg::LVL_NMI));
		take = 1'b0;
		ist_d = ist_q;
		acc_d = acc_q;
		vec_d = vec_q;
		pc_d = pc_q;
		saved_d = saved_q;
		sr_d = sr_q;
		if (wr_en && (i_paddr == irf_pkg::OFS_SR))
			sr_d = i_pwdata[15:0];
		unique case (ist_q)
			IRQ_IDLE:
			begin
				// Only a boundary looks at pending requests.
				if (i_insn_boundary && (rst_q == RT_IDLE))
				begin
					if (nmi_q)
					begin
						take = 1'b1;
						acc_d = irf_pkg::LVL_NMI;
					end
					else if ((lvl != irf_pkg::LVL_NMI) && (lvl > sr_q[2:0]))
					begin
						take = 1'b1;
						acc_d = lvl;
					end
				end
				if (take)
				begin
					saved_d = sr_q;
					sr_d[irf_pkg::SR_S] = 1'b1;
					sr_d[irf_pkg::SR_T_LO +: 2] = 2'b00;
					sr_d[2:0] = acc_d;
					pc_d = i_next_pc;
					ist_d = IRQ_ACK;
				end
			end
			IRQ_ACK:
			begin
				if (i_iack_done)
				begin
					if (i_iack_berr)
						vec_d = irf_pkg::VEC_SPURIOUS;
					else if (i_iack_autovec)
						vec_d = irf_pkg::VEC_AUTO_BASE + {5'h00, acc_q};
					else
						vec_d = i_iack_vector;
					ist_d = IRQ_PUSH;
				end
			end
			IRQ_PUSH:
			begin
				if (i_push_done)
					ist_d = IRQ_IDLE;
			end
		endcase
		// An accepted return restores the stacked status register.
		if ((rst_q == RT_CHECK) && (res_d == irf_pkg::RTE_OK))
			sr_d = rsr_q;
		// A fresh edge wins over the clear of an accepted one.
		nmi_d = nmi_edge | (nmi_q & ~(take && (acc_d == irf_pkg::LVL_NMI)));
	end

	always_ff @(posedge i_sys_clk or negedge i_rst_b)
	begin
		if (!i_rst_b)
		begin
			sr_q <= irf_pkg::SR_RST;
			saved_q <= 16'h0000;
			lvl_prev_q <= 3'h0;
			mask_prev_q <= 3'h0;
			nmi_q <= 1'b0;
			ist_q <= IRQ_IDLE;
			acc_q <= 3'h0;
			vec_q <= 8'h00;
			pc_q <= 32'h0000_0000;
		end
		else
		begin
			sr_q <= sr_d;
			saved_q <= saved_d;
			lvl_prev_q <= lvl_prev_d;
			mask_prev_q <= mask_prev_d;
			nmi_q <= nmi_d;
			ist_q <= ist_d;
			acc_q <= acc_d;
			vec_q <= vec_d;
			pc_q <= pc_d;
		end
	end

	assign o_iack_req = (ist_q == IRQ_ACK);
	assign o_iack_space = irf_pkg::SPACE_CPU;
	assign o_iack_level = acc_q;
	assign o_push_req = (ist_q == IRQ_PUSH);
	assign o_push_vector = vec_q;
	assign o_push_pc = pc_q;
	assign o_push_sr = saved_q;

	// ---------------------------------------------------------------
	// Exception return
	// ---------------------------------------------------------------
	// The block never writes the frame itself, so a rejected frame
	// stays on the stack as it was.
	always_comb
	begin
		rst_d = rst_q;
		res_d = res_q;
		rel_d = rel_q;
		fmt_err_d = 1'b0;
		bus_err_d = 1'b0;
		frame_d = frame_q;
		rssw_d = rssw_q;
		rsr_d = rsr_q;
		if (wr_en && (i_paddr == irf_pkg::OFS_RTE_FRAME))
			frame_d = i_pwdata[19:0];
		if (wr_en && (i_paddr == irf_pkg::OFS_RTE_SSW))
			rssw_d = i_pwdata[15:0];
		if (wr_en && (i_paddr == irf_pkg::OFS_RTE_SR))
			rsr_d = i_pwdata[15:0];
		unique case (rst_q)
			RT_IDLE:
			begin
				if (wr_en && (i_paddr == irf_pkg::OFS_CMD) && i_pwdata[0])
					rst_d = RT_CHECK;
			end
			RT_CHECK:
			begin
				rst_d = RT_IDLE;
				rel_d = 5'h00;
				if (i_frame_fault)
					res_d = irf_pkg::RTE_BUS_ERR;
				else if (frame_q[19:16] == irf_pkg::FMT_FOUR)
				begin
					res_d = irf_pkg::RTE_OK;
					rel_d = irf_pkg::REL_FOUR;
				end
				else if (frame_q[19:16] == irf_pkg::FMT_SIX)
				begin
					res_d = irf_pkg::RTE_OK;
					rel_d = irf_pkg::REL_SIX;
				end
				else if ((frame_q[19:16] == irf_pkg::FMT_BUSF)
					&& (frame_q[15:8] == irf_pkg::OWN_VERSION))
				begin
					res_d = irf_pkg::RTE_OK;
					rel_d = irf_pkg::REL_BUSF;
					// Lock and prefetch bits play no part here.
					if (rssw_q[irf_pkg::SSW_CLASS])
						rst_d = RT_REWRITE;
					else if (rssw_q[irf_pkg::SSW_RR])
						rst_d = RT_RERUN;
				end
				else
					res_d = irf_pkg::RTE_FMT_ERR;
				fmt_err_d = (res_d == irf_pkg::RTE_FMT_ERR);
				bus_err_d = (res_d == irf_pkg::RTE_BUS_ERR);
			end
			RT_REWRITE:
			begin
				if (i_rewrite_done)
					rst_d = i_rewrite_berr ? RT_HALT : RT_IDLE;
			end
			RT_RERUN:
			begin
				if (i_rerun_done)
					rst_d = RT_IDLE;
			end
			RT_HALT:
				rst_d = RT_HALT;
			default:
				rst_d = RT_IDLE;
		endcase
	end

	always_ff @(posedge i_sys_clk or negedge i_rst_b)
	begin
		if (!i_rst_b)
		begin
			rst_q <= RT_IDLE;
			res_q <= irf_pkg::RTE_NONE;
			rel_q <= 5'h00;
			fmt_err_q <= 1'b0;
			bus_err_q <= 1'b0;
			frame_q <= 20'h00000;
			rssw_q <= 16'h0000;
			rsr_q <= irf_pkg::SR_RST;
		end
		else
		begin
			rst_q <= rst_d;
			res_q <= res_d;
			rel_q <= rel_d;
			fmt_err_q <= fmt_err_d;
			bus_err_q <= bus_err_d;
			frame_q <= frame_d;
			rssw_q <= rssw_d;
			rsr_q <= rsr_d;
		end
	end

	assign o_fmt_err = fmt_err_q;
	assign o_bus_err = bus_err_q;
	assign o_rewrite_req = (rst_q == RT_REWRITE);
	assign o_halt = (rst_q == RT_HALT);
	assign o_rerun_req = (rst_q == RT_RERUN);
	assign o_rerun_read = rssw_q[irf_pkg::SSW_RW];
	assign o_rerun_size = rssw_q[irf_pkg::SSW_SIZ +: 2];
	assign o_rerun_space = rssw_q[irf_pkg::SSW_FC +: 3];

	// ---------------------------------------------------------------
	// Fault status word encoder
	// ---------------------------------------------------------------
	// Unused bits start at zero and are never set.
	always_comb
	begin
		fssw_d = fssw_q;
		if (i_flt_capture)
		begin
			fssw_d = 16'h0000;
			fssw_d[irf_pkg::SSW_CLASS] = i_flt_in_exc;
			fssw_d[irf_pkg::SSW_MV] = i_flt_block_move;
			fssw_d[irf_pkg::SSW_TR] = i_flt_trace_pend;
			fssw_d[irf_pkg::SSW_B1] = i_flt_ext_brk;
			fssw_d[irf_pkg::SSW_B0] = i_flt_int_brk;
			fssw_d[irf_pkg::SSW_RR] = i_flt_released;
			fssw_d[irf_pkg::SSW_RM] = i_flt_locked;
			fssw_d[irf_pkg::SSW_IN] = i_flt_prefetch | (i_flt_block_move & i_flt_refetch);
			fssw_d[irf_pkg::SSW_RW] = i_flt_read;
			fssw_d[irf_pkg::SSW_LG] = i_flt_long;
			fssw_d[irf_pkg::SSW_SIZ +: 2] = i_flt_size;
			fssw_d[irf_pkg::SSW_FC +: 3] = i_flt_space;
		end
	end

	always_ff @(posedge i_sys_clk or negedge i_rst_b)
	begin
		if (!i_rst_b)
			fssw_q <= 16'h0000;
		else
			fssw_q <= fssw_d;
	end

	// ---------------------------------------------------------------
	// Checks
	// ---------------------------------------------------------------
	property p_mask;
		@(posedge i_sys_clk) disable iff (!i_rst_b)
		(ist_q == IRQ_IDLE) && !nmi_q && (lvl <= sr_q[2:0]) |=> (ist_q == IRQ_IDLE);
	endproperty
	a_mask: assert property (p_mask) else $error("masked level taken");
	property p_boundary;
		@(posedge i_sys_clk) disable iff (!i_rst_b)
		(ist_q == IRQ_IDLE) && !i_insn_boundary |=> (ist_q == IRQ_IDLE);
	endproperty
	a_boundary: assert property (p_boundary) else $error("taken off boundary");
	property p_take;
		@(posedge i_sys_clk) disable iff (!i_rst_b)
		take |=> sr_q[irf_pkg::SR_S] && (sr_q[irf_pkg::SR_T_LO +: 2] == 2'b00)
			&& (sr_q[2:0] == acc_q) && (saved_q == $past(sr_q));
	endproperty
	a_take: assert property (p_take) else $error("status not updated");
	sequence s_ack_berr;
		o_iack_req && i_iack_done && i_iack_berr;
	endsequence
	property p_spur;
		@(posedge i_sys_clk) disable iff (!i_rst_b)
		s_ack_berr |=> o_push_req && (o_push_vector == irf_pkg::VEC_SPURIOUS);
	endproperty
	a_spur: assert property (p_spur) else $error("spurious vector wrong");
	property p_auto;
		@(posedge i_sys_clk) disable iff (!i_rst_b)
		o_iack_req && i_iack_done && !i_iack_berr && i_iack_autovec
			|=> (o_push_vector == irf_pkg::VEC_AUTO_BASE + {5'h00, o_iack_level});
	endproperty
	a_auto: assert property (p_auto) else $error("autovector wrong");
	property p_nmi;
		@(posedge i_sys_clk) disable iff (!i_rst_b)
		(lvl == irf_pkg::LVL_NMI) && ($past(lvl) != irf_pkg::LVL_NMI) |=> nmi_q || o_iack_req;
	endproperty
	a_nmi: assert property (p_nmi) else $error("level seven edge lost");
	property p_short;
		@(posedge i_sys_clk) disable iff (!i_rst_b)
		(rst_q == RT_CHECK) && !i_frame_fault && (frame_q[19:16] == irf_pkg::FMT_SIX)
			|=> (rel_q == irf_pkg::REL_SIX) && (res_q == irf_pkg::RTE_OK);
	endproperty
	a_short: assert property (p_short) else $error("six-word release wrong");
	property p_ver;
		@(posedge i_sys_clk) disable iff (!i_rst_b)
		(rst_q == RT_CHECK) && !i_frame_fault && (frame_q[19:16] == irf_pkg::FMT_BUSF)
			&& (frame_q[15:8] != irf_pkg::OWN_VERSION) |=> o_fmt_err && (rel_q == 5'h00);
	endproperty
	a_ver: assert property (p_ver) else $error("version mismatch accepted");
	property p_halt;
		@(posedge i_sys_clk) disable iff (!i_rst_b)
		o_rewrite_req && i_rewrite_done && i_rewrite_berr |=> o_halt [*2];
	endproperty
	a_halt: assert property (p_halt) else $error("no halt after rewrite fault");
	property p_ssw;
		@(posedge i_sys_clk) disable iff (!i_rst_b)
		i_flt_capture |=> (fssw_q[irf_pkg::SSW_CLASS] == $past(i_flt_in_exc))
			&& (fssw_q[13] == 1'b0) && (fssw_q[irf_pkg::SSW_B1] == $past(i_flt_ext_brk));
	endproperty
	a_ssw: assert property (p_ssw) else $error("status word wrong");
endmodule : irf_top

// *** shared/irf_lvl_if.sv ***
`timescale 1ns/10ps
// ---------------------------------------------------------------
// Raw request level in, debounced level out.
// ---------------------------------------------------------------
interface irf_lvl_if;
	logic [2:0] raw; // Request level as it arrives.
	logic [2:0] level; // Level after synchronising and debouncing.
	modport filt (input raw, output level);
	modport user (output raw, input level);
endinterface : irf_lvl_if

// *** shared/irf_pkg.sv ***
// ---------------------------------------------------------------
// Shared constants for the interrupt, return and fault-status block.
// ---------------------------------------------------------------
package irf_pkg;
	// Register byte offsets on the APB slave.
	localparam logic [7:0] OFS_SR = 8'h00;
	localparam logic [7:0] OFS_SAVED_SR = 8'h04;
	localparam logic [7:0] OFS_CMD = 8'h08;
	localparam logic [7:0] OFS_IRQ_STAT = 8'h0C;
	localparam logic [7:0] OFS_RTE_FRAME = 8'h10;
	localparam logic [7:0] OFS_RTE_SSW = 8'h14;
	localparam logic [7:0] OFS_RTE_SR = 8'h18;
	localparam logic [7:0] OFS_RTE_STAT = 8'h1C;
	localparam logic [7:0] OFS_FAULT_SSW = 8'h20;
	// Status register fields.
	localparam int SR_S = 13;
	localparam int SR_T_LO = 14;
	localparam logic [15:0] SR_RST = 16'h2700;
	// Interrupt levels and vector numbers.
	localparam logic [2:0] LVL_NMI = 3'h7;
	localparam logic [7:0] VEC_SPURIOUS = 8'h18;
	localparam logic [7:0] VEC_AUTO_BASE = 8'h18;
	localparam logic [3:0] SPACE_CPU = 4'hF;
	// Frame formats, version and stack releases in bytes.
	localparam logic [3:0] FMT_FOUR = 4'h0;
	localparam logic [3:0] FMT_SIX = 4'h2;
	localparam logic [3:0] FMT_BUSF = 4'hC;
	localparam logic [7:0] OWN_VERSION = 8'h01; // Arbitrary value.
	localparam logic [4:0] REL_FOUR = 5'h08;
	localparam logic [4:0] REL_SIX = 5'h0C;
	localparam logic [4:0] REL_BUSF = 5'h18;
	// Fault status word bit positions.
	localparam int SSW_CLASS = 15;
	localparam int SSW_MV = 14;
	localparam int SSW_TR = 12;
	localparam int SSW_B1 = 11;
	localparam int SSW_B0 = 10;
	localparam int SSW_RR = 9;
	localparam int SSW_RM = 8;
	localparam int SSW_IN = 7;
	localparam int SSW_RW = 6;
	localparam int SSW_LG = 5;
	localparam int SSW_SIZ = 3;
	localparam int SSW_FC = 0;
	// Return outcomes shown in the return status register.
	typedef enum logic [1:0] {RTE_NONE, RTE_OK, RTE_FMT_ERR, RTE_BUS_ERR} irf_rte_res_t;
endpackage : irf_pkg

// *** tb/irf_far_model.sv ***
`timescale 1ns/10ps
// ----
// Interrupting source and bus controller, answering after i_wait cycles.
// ----
module irf_far_model (
	input wire logic i_sys_clk,
	input wire logic i_rst_b,
	input wire logic i_any_req,
	input wire logic [1:0] i_mode,
	input wire logic [3:0] i_wait,
	input wire logic [7:0] i_vec,
	output logic o_done,
	output logic o_auto,
	output logic o_berr,
	output logic [7:0] o_vec
);
	logic [3:0] cnt_q; // Cycles waited on the current request.
	// One answer per request, since done clears itself on the edge after it rises.
	always_ff @(posedge i_sys_clk or negedge i_rst_b)
	begin
		if (!i_rst_b)
		begin
			cnt_q <= 4'h0;
			o_done <= 1'h0;
		end
		else if (o_done || !i_any_req)
		begin
			cnt_q <= 4'h0;
			o_done <= 1'h0;
		end
		else if (cnt_q >= i_wait)
			o_done <= 1'h1;
		else
			cnt_q <= cnt_q + 4'h1;
	end
	assign o_auto = o_done && i_mode == 2'h1;
	assign o_berr = i_mode == 2'h2;
	// Off the answer the bus shows the inverse, so a stale value cannot match.
	assign o_vec = !o_done ? ~i_vec : i_mode == 2'h3 ? 8'h0F : i_vec;
endmodule : irf_far_model

// *** tb/tb_top.sv ***
`timescale 1ns/10ps
// ----
// Self-checking bench for the interrupt, return and fault-word block.
// ----
module tb_top;
	logic clk = 1'h0, rst_b = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
	logic bnd = 1'h0, ff = 1'h0, cap = 1'h0, err;
	logic [7:0] paddr = 8'h00, vec = 8'h00, ivec, pvec;
	logic [31:0] pwdata = 32'h0, pc = 32'h0, rd, prdata, ppc;
	logic [2:0] lvl = 3'h0, ilvl, rsp;
	logic [15:0] flt = 16'h0, psr;
	logic [1:0] mode = 2'h0, rsz;
	logic [3:0] wt = 4'h0, ispc;
	logic pready, pslverr, ireq, preq, wreq, rreq, rrd, halt, done, iauto, iberr, fe, be;
	int miscompares = 0, comparisons = 0;
	logic [31:0] frames [6] = '{32'h100, 32'h20100, 32'hC0100, 32'hC0200, 32'h50100, 32'h100};
	logic [31:0] outs [6] = '{32'h801, 32'hC01, 32'h1801, 32'h2, 32'h2, 32'h3};
	always #12.5 clk = ~clk;
	irf_top irf_top_inst (.i_sys_clk(clk), .i_rst_b(rst_b), .i_psel(psel), .i_penable(penable),
		.i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
		.o_pready(pready), .o_pslverr(pslverr), .i_irq_level(lvl), .i_insn_boundary(bnd),
		.i_next_pc(pc), .o_iack_req(ireq), .o_iack_space(ispc), .o_iack_level(ilvl),
		.i_iack_done(done), .i_iack_autovec(iauto), .i_iack_berr(iberr),
		.i_iack_vector(ivec), .o_push_req(preq), .o_push_vector(pvec), .o_push_pc(ppc),
		.o_push_sr(psr), .i_push_done(done), .i_frame_fault(ff), .o_fmt_err(fe),
		.o_bus_err(be), .o_rewrite_req(wreq), .i_rewrite_done(done), .i_rewrite_berr(iberr),
		.o_rerun_req(rreq), .o_rerun_read(rrd), .o_rerun_size(rsz), .o_rerun_space(rsp),
		.i_rerun_done(done), .o_halt(halt), .i_flt_capture(cap), .i_flt_in_exc(flt[0]),
		.i_flt_block_move(flt[1]), .i_flt_refetch(flt[2]), .i_flt_trace_pend(flt[3]),
		.i_flt_ext_brk(flt[4]), .i_flt_int_brk(flt[5]), .i_flt_released(flt[6]),
		.i_flt_locked(flt[7]), .i_flt_prefetch(flt[8]), .i_flt_read(flt[9]),
		.i_flt_long(flt[10]), .i_flt_size(flt[12:11]), .i_flt_space(flt[15:13]));
	irf_far_model irf_far_model_inst (.i_sys_clk(clk), .i_rst_b(rst_b),
		.i_any_req(ireq | preq | wreq | rreq), .i_mode(mode), .i_wait(wt), .i_vec(vec),
		.o_done(done), .o_auto(iauto), .o_berr(iberr), .o_vec(ivec));
	// One APB transfer; the request stands until pready is seen at an edge.
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		psel <= 1'h1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'h1;
		@(posedge clk);
		while (pready !== 1'h1)
			@(posedge clk);
		rd = prdata;
		err = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
	endtask : apb
	// Waits a bounded time for a request: 0 acknowledge, 1 push, 2 rerun.
	task automatic await(input int k);
		repeat (30)
			if ((k == 0 ? ireq : k == 1 ? preq : rreq) !== 1'h1)
				@(negedge clk);
	endtask : await
	task automatic check(input string n, input logic [31:0] s, input logic [31:0] e);
		comparisons++;
		if (s !== e)
		begin
			miscompares++;
			$display("CHECK FAILED %s expected %h seen %h", n, e, s);
		end
	endtask : check
	function automatic logic [7:0] exp_vec(input int l);
		case (mode)
			2'h1: exp_vec = 8'h18 + 8'(l);
			2'h2: exp_vec = 8'h18;
			2'h3: exp_vec = 8'h0F;
			default: exp_vec = vec;
		endcase
	endfunction : exp_vec
	function automatic logic [31:0] exp_ssw(input logic [15:0] f);
		exp_ssw = {16'h0, f[0], f[1], 1'h0, f[3], f[4], f[5], f[6], f[7],
			f[8] | (f[1] & f[2]), f[9], f[10], f[12:11], f[15:13]};
	endfunction : exp_ssw
	task automatic tally_and_finish();
		$display("comparisons %0d miscompares %0d", comparisons, miscompares);
		if (miscompares == 0 && comparisons > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : tally_and_finish
	// A hang costs a mismatch and ends the run through the same closing task.
	initial
	begin
		repeat (8000) @(posedge clk);
		miscompares++;
		tally_and_finish();
	end
	initial
	begin
		logic [15:0] m;
		void'($urandom(32'hB1F01E4A));
		repeat (16) @(posedge clk);
		rst_b <= 1'h1;
		apb(1'h0, 8'h40, 32'h0);
		check("unmapped", {31'h0, err}, 32'h1);
		for (int l = 1; l < 8; l++)
		begin
			m = (l == 7) ? 16'hC007 : 16'hC003;
			apb(1'h1, irf_pkg::OFS_SR, {16'h0, m});
			@(posedge clk);
			bnd <= 1'h0;
			lvl <= 3'(l);
			// Levels four to seven walk through every answer kind once.
			mode <= 2'(l);
			wt <= 4'($urandom % 4);
			vec <= 8'($urandom);
			pc <= $urandom;
			repeat (8) @(posedge clk);
			check("no_boundary", {31'h0, ireq}, 32'h0);
			bnd <= 1'h1;
			await(0);
			if (l < 4)
				check("masked", {31'h0, ireq}, 32'h0);
			else
			begin
				check("iack", {ispc, 24'h0, ireq, ilvl}, {4'hF, 24'h0, 1'h1, 3'(l)});
				await(1);
				check("vector", {23'h0, preq, pvec}, {23'h0, 1'h1, exp_vec(l)});
				check("push_pc", ppc, pc);
				check("push_sr", {16'h0, psr}, {16'h0, m});
				apb(1'h0, irf_pkg::OFS_SR, 32'h0);
				check("sr_taken", rd, 32'h2000 | l);
			end
			@(posedge clk);
			lvl <= 3'h0;
			repeat (8) @(posedge clk);
		end
		$display("test interrupts done");
		apb(1'h1, irf_pkg::OFS_RTE_SR, 32'h2404);
		for (int k = 0; k < 6; k++)
		begin
			apb(1'h1, irf_pkg::OFS_RTE_FRAME, frames[k]);
			apb(1'h1, irf_pkg::OFS_RTE_SSW, 32'h0);
			ff <= (k == 5);
			apb(1'h1, irf_pkg::OFS_CMD, 32'h1);
			// The error pulses stand for the one cycle after the check cycle.
			@(negedge clk);
			@(negedge clk);
			check("rte_pulse", {30'h0, fe, be}, {30'h0, outs[k][1:0] == 2'h2,
				outs[k][1:0] == 2'h3});
			apb(1'h0, irf_pkg::OFS_RTE_STAT, 32'h0);
			check("rte_stat", rd & 32'h1F07, outs[k]);
			apb(1'h0, irf_pkg::OFS_RTE_FRAME, 32'h0);
			check("frame_kept", rd, frames[k]);
		end
		apb(1'h0, irf_pkg::OFS_SR, 32'h0);
		check("sr_restored", rd, 32'h2404);
		ff <= 1'h0;
		apb(1'h1, irf_pkg::OFS_RTE_FRAME, 32'hC0100);
		apb(1'h1, irf_pkg::OFS_RTE_SSW, 32'h255);
		apb(1'h1, irf_pkg::OFS_CMD, 32'h1);
		await(2);
		check("rerun", {25'h0, rreq, rrd, rsz, rsp}, 32'h75);
		$display("test returns done");
		repeat (6)
		begin
			m = 16'($urandom);
			m[12:11] = 2'($urandom % 3);
			@(posedge clk);
			flt <= m;
			cap <= 1'h1;
			@(posedge clk);
			cap <= 1'h0;
			apb(1'h0, irf_pkg::OFS_FAULT_SSW, 32'h0);
			check("fault_word", rd, exp_ssw(m));
		end
		$display("test fault word done");
		@(posedge clk);
		mode <= 2'h2;
		apb(1'h1, irf_pkg::OFS_RTE_SSW, 32'h8000);
		apb(1'h1, irf_pkg::OFS_CMD, 32'h1);
		repeat (20) @(posedge clk);
		check("halt", {31'h0, halt}, 32'h1);
		$display("test rewrite failure done");
		tally_and_finish();
	end
endmodule : tb_top
